// file: logic/usb_ep0_defs.vh
// Shared constants of the endpoint 0 handshake control block.
// Assumes inclusion by bare name from the files under logic/.
`ifndef USB_EP0_DEFS_VH
`define USB_EP0_DEFS_VH

// ***********************************************************
// FIFO geometry
// ***********************************************************
`define EP0_FIFO_DEPTH 8
`define EP0_FIFO_AW 3
`define EP0_CNT_W 4
`define EP0_FIFO_FULL 4'h8
`define EP0_CNT_ONE 4'h1
`define EP0_CNT_ZERO 4'h0
`define EP0_SETUP_LEN 8

// ***********************************************************
// Register byte offsets on the Wishbone bus
// ***********************************************************
`define REG_NAK_CTRL 8'h00
`define REG_RX_FIFO 8'h04
`define REG_TX_FIFO 8'h08
`define REG_RX_LEN 8'h0C
`define REG_SETUP_LO 8'h10
`define REG_SETUP_HI 8'h14
`define REG_IRQ_STAT 8'h18
`define REG_IRQ_CLR 8'h1C
`define REG_IRQ_MASK 8'h20
`define REG_DATA_END 8'h24
`define REG_FIFO_CLR 8'h28

// ***********************************************************
// Field positions and reset values
// ***********************************************************
`define NAK_OUT_BIT 1
`define NAK_IN_BIT 0
`define DEND_EP0_BIT 0
`define CLR_RX_BIT 0
`define CLR_TX_BIT 1
`define IRQ_OVERRUN 0
`define IRQ_DECODE 1
`define IRQ_RX_PKT 2
`define IRQ_TX_ACK 3
`define IRQ_W 4
`define IRQ_RESET 4'h0
`define MASK_RESET 4'h0

// ***********************************************************
// Timing: a FIFO clear shows on the fifth clock
// ***********************************************************
`define CLR_STAGES 4

`endif

// file: logic/ep0_fifo.v
// Byte FIFO for the control endpoint, eight bytes deep.
// Assumes one clock; pops never exceed what was pushed.
`timescale 1ns/1ps
`include "usb_ep0_defs.vh"

module ep0_fifo (
	input wire clock,
	input wire rst_b,
	input wire push,
	input wire [7:0] pushData,
	input wire pop,
	input wire rewind,
	input wire clear,
	output wire [7:0] popData,
	output wire [`EP0_CNT_W-1:0] count,
	output wire full
);

	// ***********************************************************
	// Storage and pointers
	// ***********************************************************
	reg [7:0] mem [0:`EP0_FIFO_DEPTH-1]; // Packet bytes
	reg [`EP0_CNT_W-1:0] wrCnt_q; // Bytes written
	reg [`EP0_CNT_W-1:0] rdIdx_q; // Read position

	// Reads never consume storage, so a rewind replays the packet
	assign count = wrCnt_q - rdIdx_q;
	assign full = (wrCnt_q == `EP0_FIFO_FULL);
	assign popData = mem[rdIdx_q[`EP0_FIFO_AW-1:0]];

	// ***********************************************************
	// Pointer update; clear beats every other action
	// ***********************************************************
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wrCnt_q <= `EP0_CNT_ZERO;
			rdIdx_q <= `EP0_CNT_ZERO;
		end else if (clear) begin
			wrCnt_q <= `EP0_CNT_ZERO;
			rdIdx_q <= `EP0_CNT_ZERO;
		end else begin
			// Push refused once full
			if (push && !full)
				wrCnt_q <= wrCnt_q + `EP0_CNT_ONE;
			// Rewind restarts reading from the first byte
			if (rewind)
				rdIdx_q <= `EP0_CNT_ZERO;
			else if (pop && (count != `EP0_CNT_ZERO))
				rdIdx_q <= rdIdx_q + `EP0_CNT_ONE;
		end
	end

	// Data array needs no reset
	always @(posedge clock) begin
		if (push && !full && !clear)
			mem[wrCnt_q[`EP0_FIFO_AW-1:0]] <= pushData;
	end

endmodule

// file: logic/usb_ep0_nak_control.v
// Endpoint 0 NAK and handshake control with its Wishbone registers.
// Assumes the serial engine signals run on the same clock as the bus.
//
// Functional notes
// - Out NAK bit decides OUT token answer
// - Good OUT packet sets out NAK
// - Receive FIFO drained clears out NAK
// - Firmware set NAK holds until firmware clears
// - Receive FIFO clear clears out NAK
// - Ready data goes on next IN token
// - SETUP mid transfer sets overrun flag
// - Zero write clears overrun; newest setup shown
// - FIFO clear shows four clocks later
// - Out NAK writes ignored while NAK sent
`timescale 1ns/1ps
`include "usb_ep0_defs.vh"

module usb_ep0_nak_control (
	input wire clock,
	input wire rst_b,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	output reg irq,
	input wire setupStart,
	input wire setupByteValid,
	input wire [7:0] setupByte,
	input wire setupDone,
	input wire ctrlDone,
	input wire outToken,
	input wire outByteValid,
	input wire [7:0] outByte,
	input wire outDataOk,
	input wire outDataBad,
	input wire inToken,
	input wire hostAck,
	input wire statusStage,
	input wire ep2Naking,
	output reg outAckReply,
	output reg outNakReply,
	output reg inNakReply,
	output reg txValid,
	output reg [7:0] txByte,
	output reg txEnd
);

	// ***********************************************************
	// Helpers
	// ***********************************************************
	// Word decode; the low two address bits are ignored
	function hit;
		input [7:0] adr;
		input [7:0] off;
		begin
			hit = (adr[7:2] == off[7:2]);
		end
	endfunction

	// ***********************************************************
	// State
	// ***********************************************************
	reg outNak_q; // Answer NAK to OUT tokens
	reg outNak_d;
	reg inReady_q; // Transmit data queued for IN
	reg inReady_d;
	reg rxOpen_q; // OUT data phase accepted
	reg xferActive_q; // Control transfer in progress
	reg [`EP0_FIFO_AW-1:0] setupIdx_q; // Next setup byte slot
	reg [7:0] setupBuf [0:`EP0_SETUP_LEN-1]; // Latest setup packet
	reg [`EP0_CNT_W-1:0] rxLen_q; // Length of last packet
	reg [`IRQ_W-1:0] irqStat_q; // Sticky event bits
	reg [`IRQ_W-1:0] irqStat_d;
	reg [`IRQ_W-1:0] mask_q; // Interrupt enables
	reg [`CLR_STAGES-1:0] rxClrPipe_q; // Delayed receive clear
	reg [`CLR_STAGES-1:0] txClrPipe_q; // Delayed transmit clear
	reg [1:0] txState_q; // Transmit sequencer
	reg [31:0] rdData; // Read mux result

	// Transmit sequencer codes
	localparam [1:0] TX_IDLE = 2'h0; // No IN data moving
	localparam [1:0] TX_SEND = 2'h1; // Bytes going out
	localparam [1:0] TX_WAIT = 2'h2; // Waiting for host ACK

	// ***********************************************************
	// Bus decode
	// ***********************************************************
	// One request per ack; the cycle with ack high blocks a repeat
	wire busReq = cyc_i && stb_i && !ack_o;
	wire wrAcc = busReq && we_i && sel_i[0];
	wire rdAcc = busReq && !we_i;

	// ***********************************************************
	// FIFOs
	// ***********************************************************
	wire [7:0] rxPopData;
	wire [`EP0_CNT_W-1:0] rxCount;
	wire [7:0] txPopData;
	wire [`EP0_CNT_W-1:0] txCount;
	wire txFull;

	wire rxClrApply = rxClrPipe_q[`CLR_STAGES-1];
	wire txClrApply = txClrPipe_q[`CLR_STAGES-1];

	// Firmware pop, only when data remains
	wire rxPop = rdAcc && hit(adr_i, `REG_RX_FIFO) &&
		(rxCount != `EP0_CNT_ZERO);
	// Last byte read empties the FIFO
	wire rxEmptied = rxPop && (rxCount == `EP0_CNT_ONE);
	wire rxPush = rxOpen_q && outByteValid;
	// A corrupt packet is dropped whole
	wire rxClear = rxClrApply || (rxOpen_q && outDataBad);
	wire rxGood = rxOpen_q && outDataOk;

	// Firmware may not change a packet already queued
	wire txPush = wrAcc && hit(adr_i, `REG_TX_FIFO) && !inReady_q;
	wire txFills = txPush && (txCount == `EP0_FIFO_FULL - `EP0_CNT_ONE);
	wire txSendStep = (txState_q == TX_SEND) &&
		(txCount != `EP0_CNT_ZERO);
	wire txStart = inToken && inReady_q && (txState_q != TX_SEND);
	wire txAcked = hostAck && (txState_q == TX_WAIT);
	wire txAbort = statusStage && inReady_q;
	wire txClear = txClrApply || txAcked || txAbort;

	ep0_fifo rxFifo (
		.clock(clock),
		.rst_b(rst_b),
		.push(rxPush),
		.pushData(outByte),
		.pop(rxPop),
		.rewind(1'b0),
		.clear(rxClear),
		.popData(rxPopData),
		.count(rxCount),
		.full()
	);

	ep0_fifo txFifo (
		.clock(clock),
		.rst_b(rst_b),
		.push(txPush),
		.pushData(dat_i[7:0]),
		.pop(txSendStep),
		.rewind(txStart),
		.clear(txClear),
		.popData(txPopData),
		.count(txCount),
		.full(txFull)
	);

	// ***********************************************************
	// Out NAK bit
	// ***********************************************************
	// NAK being sent on endpoint 0 reads or endpoint 2 locks the bit
	wire nakBusy = inNakReply || ep2Naking;
	wire fwNakWr = wrAcc && hit(adr_i, `REG_NAK_CTRL) && !nakBusy;

	// Clears first, firmware next, hardware set last so it wins
	always @* begin
		outNak_d = outNak_q;
		if (rxEmptied)
			outNak_d = 1'b0;
		if (rxClrApply)
			outNak_d = 1'b0;
		if (fwNakWr)
			outNak_d = dat_i[`NAK_OUT_BIT];
		if (rxGood)
			outNak_d = 1'b1;
	end

	// ***********************************************************
	// In ready bit
	// ***********************************************************
	wire dataEndWr = wrAcc && hit(adr_i, `REG_DATA_END) &&
		dat_i[`DEND_EP0_BIT];

	always @* begin
		inReady_d = inReady_q;
		// The host ack, an abort or the delayed transmit clear releases the packet
		if (txAcked)
			inReady_d = 1'b0;
		if (txAbort)
			inReady_d = 1'b0;
		if (txClrApply)
			inReady_d = 1'b0;
		// Short packet by data end, full packet by itself
		if (dataEndWr || txFills)
			inReady_d = 1'b1;
	end

	// ***********************************************************
	// Interrupt status
	// ***********************************************************
	wire overrunEv = setupStart && xferActive_q;
	wire [`IRQ_W-1:0] evSet = {txAcked, rxGood, setupDone, overrunEv};
	wire [`IRQ_W-1:0] w1cClr = (wrAcc && hit(adr_i, `REG_IRQ_STAT)) ?
		dat_i[`IRQ_W-1:0] : `IRQ_RESET;
	// Clear register works on written zeros
	wire [`IRQ_W-1:0] w0Clr = (wrAcc && hit(adr_i, `REG_IRQ_CLR)) ?
		~dat_i[`IRQ_W-1:0] : `IRQ_RESET;

	// A new event in the clearing cycle survives
	always @* begin
		irqStat_d = (irqStat_q & ~(w1cClr | w0Clr)) | evSet;
	end

	// ***********************************************************
	// Read mux
	// ***********************************************************
	always @* begin
		rdData = 32'h00000000;
		// Word index widened to the offsets' width
		case ({2'h0, adr_i[7:2]})
		`REG_NAK_CTRL >> 2: begin
			rdData[`NAK_OUT_BIT] = outNak_q;
			rdData[`NAK_IN_BIT] = inReady_q;
		end
		`REG_RX_FIFO >> 2: begin
			rdData[7:0] = rxPopData;
		end
		`REG_RX_LEN >> 2: begin
			rdData[`EP0_CNT_W-1:0] = rxLen_q;
		end
		`REG_SETUP_LO >> 2: begin
			rdData = {setupBuf[3], setupBuf[2], setupBuf[1],
				setupBuf[0]};
		end
		`REG_SETUP_HI >> 2: begin
			rdData = {setupBuf[7], setupBuf[6], setupBuf[5],
				setupBuf[4]};
		end
		`REG_IRQ_STAT >> 2: begin
			rdData[`IRQ_W-1:0] = irqStat_q;
		end
		`REG_IRQ_MASK >> 2: begin
			rdData[`IRQ_W-1:0] = mask_q;
		end
		// Unmapped and write-only words read zero
		default: begin
			rdData = 32'h00000000;
		end
		endcase
	end

	// ***********************************************************
	// Bus answer and control registers
	// ***********************************************************
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
			outNak_q <= 1'b0;
			inReady_q <= 1'b0;
			irqStat_q <= `IRQ_RESET;
			mask_q <= `MASK_RESET;
			irq <= 1'b0;
			rxClrPipe_q <= {`CLR_STAGES{1'b0}};
			txClrPipe_q <= {`CLR_STAGES{1'b0}};
		end else begin
			// Every access, mapped or not, gets ack next cycle
			ack_o <= busReq;
			if (rdAcc)
				dat_o <= rdData;
			outNak_q <= outNak_d;
			inReady_q <= inReady_d;
			irqStat_q <= irqStat_d;
			if (wrAcc && hit(adr_i, `REG_IRQ_MASK))
				mask_q <= dat_i[`IRQ_W-1:0];
			// Level output, one clock behind the status bits
			irq <= |(irqStat_q & mask_q);
			// Clear requests ripple four stages, then act
			rxClrPipe_q <= {rxClrPipe_q[`CLR_STAGES-2:0],
				wrAcc && hit(adr_i, `REG_FIFO_CLR) &&
				dat_i[`CLR_RX_BIT]};
			txClrPipe_q <= {txClrPipe_q[`CLR_STAGES-2:0],
				wrAcc && hit(adr_i, `REG_FIFO_CLR) &&
				dat_i[`CLR_TX_BIT]};
		end
	end

	// ***********************************************************
	// Setup capture and overrun tracking
	// ***********************************************************
	// Newest setup always overwrites, so a reread sees it
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			setupIdx_q <= {`EP0_FIFO_AW{1'b0}};
			xferActive_q <= 1'b0;
		end else begin
			if (setupStart)
				setupIdx_q <= {`EP0_FIFO_AW{1'b0}};
			else if (setupByteValid)
				setupIdx_q <= setupIdx_q + 1'b1;
			// Setup done wins over control done in the same cycle
			if (setupDone)
				xferActive_q <= 1'b1;
			else if (ctrlDone)
				xferActive_q <= 1'b0;
		end
	end

	// Setup bytes need no reset
	always @(posedge clock) begin
		if (setupByteValid && !setupStart)
			setupBuf[setupIdx_q] <= setupByte;
	end

	// ***********************************************************
	// OUT data phase
	// ***********************************************************
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rxOpen_q <= 1'b0;
			rxLen_q <= `EP0_CNT_ZERO;
			outAckReply <= 1'b0;
			outNakReply <= 1'b0;
		end else begin
			// Accept data only while the NAK bit is low
			if (outToken && !outNak_q)
				rxOpen_q <= 1'b1;
			else if (outDataOk || outDataBad)
				rxOpen_q <= 1'b0;
			outNakReply <= outToken && outNak_q;
			outAckReply <= rxGood;
			// Length register holds the packet size
			if (rxGood)
				rxLen_q <= rxCount;
			else if (rxClear)
				rxLen_q <= `EP0_CNT_ZERO;
		end
	end

	// ***********************************************************
	// IN data phase
	// ***********************************************************
	// Packet stays in the FIFO until acked, so a retry replays it
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			txState_q <= TX_IDLE;
			txValid <= 1'b0;
			txByte <= 8'h00;
			txEnd <= 1'b0;
			inNakReply <= 1'b0;
		end else begin
			txValid <= 1'b0;
			txEnd <= 1'b0;
			inNakReply <= inToken && !inReady_q;
			case (txState_q)
			TX_IDLE: begin
				// First IN token after ready carries data
				if (txStart)
					txState_q <= TX_SEND;
			end
			TX_SEND: begin
				if (txAbort || txClrApply) begin
					txState_q <= TX_IDLE;
				end else if (txCount != `EP0_CNT_ZERO) begin
					txValid <= 1'b1;
					txByte <= txPopData;
				end else begin
					// Count at zero ends the packet; zero-length if nothing was queued
					txEnd <= 1'b1;
					txState_q <= TX_WAIT;
				end
			end
			TX_WAIT: begin
				if (txAcked || txAbort || txClrApply)
					txState_q <= TX_IDLE;
				else if (txStart)
					txState_q <= TX_SEND;
			end
			default: begin
				txState_q <= TX_IDLE;
			end
			endcase
		end
	end

endmodule

// file: sim/ep0_port_checker.sv
// Port checks for the endpoint 0 handshake block.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps

module ep0_port_checker (
	input wire clock,
	input wire rst_b,
	input wire cyc_i,
	input wire stb_i,
	input wire ack_o,
	input wire outToken,
	input wire outDataOk,
	input wire inToken,
	input wire outAckReply,
	input wire outNakReply,
	input wire inNakReply,
	input wire txValid,
	input wire txEnd
);
	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_ack_one_cycle: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_on_request: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus request not answered");
	a_ack_has_request: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	a_out_nak_token: assert property (outNakReply |-> $past(outToken))
		else $error("out NAK without token");
	a_single_answer: assert property (!(outAckReply && outNakReply))
		else $error("out ACK and NAK together");
	a_ack_good_pkt: assert property (outAckReply |-> $past(outDataOk))
		else $error("out ACK without good packet");
	a_in_nak_token: assert property (inNakReply |-> $past(inToken))
		else $error("in NAK without token");
	a_data_after_token: assert property (
		$rose(txValid) |-> $past(inToken, 2))
		else $error("in data not two cycles after token");
	a_end_closes_data: assert property ($fell(txValid) |-> txEnd)
		else $error("in data not closed by end");
	a_end_one_pulse: assert property (txEnd |=> !txEnd && !txValid)
		else $error("end pulse too long");
endmodule

bind usb_ep0_nak_control ep0_port_checker chk (
	.clock(clock), .rst_b(rst_b), .cyc_i(cyc_i), .stb_i(stb_i),
	.ack_o(ack_o), .outToken(outToken), .outDataOk(outDataOk),
	.inToken(inToken), .outAckReply(outAckReply),
	.outNakReply(outNakReply), .inNakReply(inNakReply),
	.txValid(txValid), .txEnd(txEnd)
);

// file: sim/usb_host_model.sv
// Behavioural USB host driving the endpoint 0 link strobes.
// Assumes the tasks are called just after a rising clock edge.
`timescale 1ns/1ps

module usb_host_model (
	input wire clock,
	input wire outAckReply,
	input wire outNakReply,
	input wire inNakReply,
	input wire txValid,
	input wire [7:0] txByte,
	input wire txEnd,
	output reg setupStart,
	output reg setupByteValid,
	output reg [7:0] setupByte,
	output reg setupDone,
	output reg ctrlDone,
	output reg outToken,
	output reg outByteValid,
	output reg [7:0] outByte,
	output reg outDataOk,
	output reg outDataBad,
	output reg inToken,
	output reg hostAck,
	output reg statusStage,
	output reg ep2Naking
);
	integer outAcks = 0; // Handshakes seen
	integer outNaks = 0;
	integer inNaks = 0;
	logic [7:0] got[$]; // IN data received
	// Idle lines; byte lines never rest at a stale value
	initial begin
		{setupStart, setupByteValid, setupDone, ctrlDone} = 4'h0;
		{outToken, outByteValid, outDataOk, outDataBad} = 4'h0;
		{inToken, hostAck, statusStage, ep2Naking} = 4'h0;
		setupByte = 8'hA5;
		outByte = 8'h5A;
	end
	// Collect device answers
	always @(posedge clock) begin
		if (outAckReply) outAcks <= outAcks + 1;
		if (outNakReply) outNaks <= outNaks + 1;
		if (inNakReply) inNaks <= inNaks + 1;
		if (txValid) got.push_back(txByte);
	end
	// One-cycle strobe: 0 in, 1 ack, 2 status, 3 done, else out
	task strobe(input integer k);
		begin
			@(posedge clock);
			case (k)
			0: inToken <= 1'b1;
			1: hostAck <= 1'b1;
			2: statusStage <= 1'b1;
			3: ctrlDone <= 1'b1;
			default: outToken <= 1'b1;
			endcase
			@(posedge clock);
			{inToken, hostAck, statusStage, ctrlDone, outToken} <= 5'h00;
		end
	endtask
	// Eight setup bytes, low byte first, then the done pulse
	task send_setup(input [63:0] pkt);
		integer i;
		begin
			@(posedge clock);
			setupStart <= 1'b1;
			for (i = 0; i < 9; i = i + 1) begin
				@(posedge clock);
				setupStart <= 1'b0;
				setupByteValid <= (i < 8);
				setupByte <= (i < 8) ? pkt[8*(i%8)+:8] : ~setupByte;
				setupDone <= (i == 8);
			end
			@(posedge clock);
			setupDone <= 1'b0;
		end
	endtask
	// OUT token, n bytes from 30h, then the verdict a cycle apart
	task send_out(input integer n, input good);
		integer i;
		begin
			@(posedge clock);
			outToken <= 1'b1;
			for (i = 0; i <= n; i = i + 1) begin
				@(posedge clock);
				outToken <= 1'b0;
				outByteValid <= (i < n);
				outByte <= (i < n) ? 8'h30 + i[7:0] : ~outByte;
				outDataOk <= (i == n) && good;
				outDataBad <= (i == n) && !good;
			end
			@(posedge clock);
			{outDataOk, outDataBad} <= 2'h0;
		end
	endtask
	// Endpoint 2 NAK level
	task set_ep2(input v);
		begin
			ep2Naking <= v;
			@(posedge clock);
		end
	endtask
endmodule

// file: sim/tb.sv
// Self-checking bench for the endpoint 0 handshake block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps

module tb;
	reg clock, rst_b, cyc_i, stb_i, we_i;
	reg [7:0] adr_i;
	reg [3:0] sel_i;
	reg [31:0] dat_i, q;
	wire [31:0] dat_o;
	wire ack_o, irq, setupStart, setupByteValid, setupDone, ctrlDone;
	wire outToken, outByteValid, outDataOk, outDataBad, inToken, hostAck;
	wire statusStage, ep2Naking, outAckReply, outNakReply, inNakReply;
	wire txValid, txEnd;
	wire [7:0] setupByte, outByte, txByte;
	integer mismatches = 0;
	integer samplesChecked = 0;
	integer i, k;

	usb_ep0_nak_control uut (.clock(clock), .rst_b(rst_b), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq(irq),
		.setupStart(setupStart), .setupByteValid(setupByteValid),
		.setupByte(setupByte), .setupDone(setupDone),
		.ctrlDone(ctrlDone), .outToken(outToken),
		.outByteValid(outByteValid), .outByte(outByte),
		.outDataOk(outDataOk), .outDataBad(outDataBad),
		.inToken(inToken), .hostAck(hostAck),
		.statusStage(statusStage), .ep2Naking(ep2Naking),
		.outAckReply(outAckReply), .outNakReply(outNakReply),
		.inNakReply(inNakReply), .txValid(txValid), .txByte(txByte),
		.txEnd(txEnd));
	usb_host_model host (.clock(clock), .outAckReply(outAckReply),
		.outNakReply(outNakReply), .inNakReply(inNakReply),
		.txValid(txValid), .txByte(txByte), .txEnd(txEnd),
		.setupStart(setupStart), .setupByteValid(setupByteValid),
		.setupByte(setupByte), .setupDone(setupDone),
		.ctrlDone(ctrlDone), .outToken(outToken),
		.outByteValid(outByteValid), .outByte(outByte),
		.outDataOk(outDataOk), .outDataBad(outDataBad),
		.inToken(inToken), .hostAck(hostAck),
		.statusStage(statusStage), .ep2Naking(ep2Naking));

	// ****************
	// Bench tasks
	// ****************
	task closeOut;
		begin
			$display("checks %0d mismatches %0d", samplesChecked, mismatches);
			if (mismatches == 0 && samplesChecked > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task check(input [31:0] seen, input [31:0] exp);
		begin
			samplesChecked = samplesChecked + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	// Classic cycle; request held until ack is sampled
	task wb(input w, input [7:0] a, input [31:0] d);
		integer n;
		begin
			cyc_i <= 1'b1;
			stb_i <= 1'b1;
			we_i <= w;
			adr_i <= a;
			dat_i <= d;
			n = 0;
			do begin
				@(posedge clock);
				n = n + 1;
			end while (ack_o !== 1'b1 && n < 20);
			q = dat_o;
			cyc_i <= 1'b0;
			stb_i <= 1'b0;
			if (ack_o !== 1'b1) begin
				mismatches = mismatches + 1;
				closeOut;
			end
			@(posedge clock);
		end
	endtask
	task rd(input [7:0] a, input [31:0] e);
		begin
			wb(1'b0, a, 32'h0);
			check(q, e);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		wb(1'b1, a, d);
	endtask
	task idle(input integer n);
		repeat (n) @(posedge clock);
	endtask

	// Free-running 25 MHz clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ****************
	// Scenarios
	// ****************
	initial begin
		{rst_b, cyc_i, stb_i, we_i} = 4'h0;
		adr_i = 8'h00;
		sel_i = 4'hF;
		dat_i = 32'h0;
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		rd(8'h00, 32'h0);
		rd(8'h18, 32'h0);
		rd(8'h20, 32'h0);
		rd(8'h3C, 32'h0);
		// Firmware NAK stays until firmware clears it
		wr(8'h00, 32'h2);
		rd(8'h00, 32'h2);
		k = host.outNaks;
		host.strobe(4);
		idle(2);
		check(host.outNaks - k, 32'h1);
		wr(8'h00, 32'h1);
		rd(8'h00, 32'h0);
		// Good packet sets NAK; draining the FIFO clears it
		k = host.outAcks;
		host.send_out(3, 1'b1);
		idle(2);
		check(host.outAcks - k, 32'h1);
		rd(8'h00, 32'h2);
		rd(8'h18, 32'h4);
		rd(8'h0C, 32'h3);
		for (i = 0; i < 3; i++) rd(8'h04, 32'h30 + i);
		rd(8'h00, 32'h0);
		rd(8'h18, 32'h4);
		// FIFO clear is late by design, then drops NAK
		host.send_out(2, 1'b1);
		wr(8'h28, 32'h1);
		rd(8'h00, 32'h2);
		idle(4);
		rd(8'h00, 32'h0);
		// A corrupt packet is dropped, no ACK, NAK stays low
		k = host.outAcks;
		host.send_out(2, 1'b0);
		idle(2);
		check(host.outAcks - k, 32'h0);
		rd(8'h00, 32'h0);
		rd(8'h0C, 32'h0);
		host.set_ep2(1'b1);
		wr(8'h00, 32'h2);
		rd(8'h00, 32'h0);
		host.set_ep2(1'b0);
		// A write without its low byte lane is ignored
		sel_i <= 4'h0;
		wr(8'h00, 32'h2);
		sel_i <= 4'hF;
		rd(8'h00, 32'h0);
		// Control read: NAK until ready, replay until host ACK
		wr(8'h18, 32'hF);
		host.send_setup(64'h0807060504030201);
		wr(8'h1C, 32'hE);
		rd(8'h10, 32'h04030201);
		rd(8'h14, 32'h08070605);
		for (i = 0; i < 3; i++) wr(8'h08, 32'hC0 + i);
		k = host.inNaks;
		host.strobe(0);
		idle(2);
		check(host.inNaks - k, 32'h1);
		rd(8'h18, 32'h2);
		wr(8'h24, 32'h1);
		rd(8'h00, 32'h1);
		repeat (2) begin
			host.strobe(0);
			idle(6);
		end
		check(host.got.size(), 32'h6);
		for (i = 0; i < 6; i++) check(host.got[i], 32'hC0 + i % 3);
		host.strobe(1);
		idle(2);
		rd(8'h00, 32'h0);
		rd(8'h18, 32'hA);
		host.strobe(3);
		// SETUP in mid-transfer: overrun, interrupt, newest packet
		wr(8'h18, 32'hF);
		host.send_setup(64'h1111111111111111);
		host.send_setup(64'h2222222222222222);
		rd(8'h18, 32'h3);
		check({31'h0, irq}, 32'h0);
		wr(8'h20, 32'h1);
		check({31'h0, irq}, 32'h1);
		wr(8'h1C, 32'hE);
		check({31'h0, irq}, 32'h0);
		rd(8'h18, 32'h2);
		rd(8'h10, 32'h22222222);
		host.strobe(3);
		// Full FIFO readies; early status stage flushes
		for (i = 0; i < 8; i++) wr(8'h08, i);
		rd(8'h00, 32'h1);
		host.strobe(2);
		idle(2);
		rd(8'h00, 32'h0);
		k = host.inNaks;
		host.strobe(0);
		idle(2);
		check(host.inNaks - k, 32'h1);
		// Delayed transmit clear drops queued bytes
		wr(8'h08, 32'h55);
		wr(8'h28, 32'h2);
		idle(4);
		wr(8'h08, 32'h77);
		wr(8'h24, 32'h1);
		host.strobe(0);
		idle(6);
		check(host.got.size(), 32'h7);
		check(host.got[6], 32'h77);
		// Mid-run reset returns every register except the setup packet words and the receive FIFO data word to zero
		rst_b <= 1'b0;
		idle(2);
		rst_b <= 1'b1;
		idle(1);
		rd(8'h00, 32'h0);
		rd(8'h18, 32'h0);
		rd(8'h20, 32'h0);
		closeOut;
	end
endmodule
